/* File: tb/hwd_host.sv */
// Host model that issues register frames to the bank.
// Assumes the bench calls xfer; all changes land on falling clock edges.
`timescale 1ns/1ps
module hwd_host (
   input  wire logic        i_clk,
   output logic             o_wr_en,
   output logic             o_rd_en,
   output logic [6:0]       o_addr,
   output logic [15:0]      o_wr_data
);
   initial
   begin
      o_wr_en   = 1'b0;
      o_rd_en   = 1'b0;
      o_addr    = 7'h00;
      o_wr_data = 16'h0000;
   end

   task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d);
      @(negedge i_clk);
      o_addr    = a;
      o_wr_data = d;
      o_wr_en   = wr;
      o_rd_en   = ~wr;
      @(negedge i_clk);
      o_wr_en   = 1'b0;
      o_rd_en   = 1'b0;
      // Released bus shows inverse data so a stale value never matches
      o_addr    = ~a;
      o_wr_data = ~d;
   endtask : xfer
endmodule : hwd_host

/* File: tb/tb.sv */
// Self-checking bench for the register bank.
// Assumes shortened wait counts; the host model drives the register strobes.
`timescale 1ns/1ps
module tb;
   localparam int TW = 20;
   localparam int RL = 10;
   localparam int RS = 4;
   logic        clk = 1'b0;
   logic        rst;
   logic [5:0]  ev;
   logic        pin_fo;
   logic        fail_st;
   logic        wr_en, rd_en, rd_q;
   logic [6:0]  addr;
   logic [15:0] wdat, rdat, v;
   logic        ov, sh, rdly, rlow, fo, th, wdu, wdl, win, cks, lo;
   logic [2:0]  per;
   logic [13:0] pms;
   logic [15:0] exp_q[$];
   int          n_mismatch = 0;
   int          check_count = 0;
   int          seed;
   int          n;
   int          ms_tab[8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

   always #20 clk = ~clk;

   hwd_host u_host (.i_clk(clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
                    .o_wr_data(wdat));

   hwd_regs #(.THERM_WAIT_CYC(TW), .RST_LONG_CYC(RL), .RST_SHORT_CYC(RS)) u_dut (
      .I_CLK(clk), .I_RST(rst), .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr),
      .I_WR_DATA(wdat), .I_SOFT_RESET_REQ(ev[0]), .I_RESTART_ENTRY(ev[1]),
      .I_STOP_TO_NORMAL(ev[2]), .I_BUS_WAKE_IN_STOP(ev[3]), .I_PIN_IS_FAIL_OUT(pin_fo),
      .I_FAILURE_STATUS(fail_st), .I_THERM_EVENT(ev[4]), .I_THERM_CALM(ev[5]),
      .O_RD_DATA(rdat), .O_OV_THRESH_HIGH(ov), .O_SAMPLE_HOLD_OFF(sh),
      .O_RESET_DELAY_SHORT(rdly), .O_RESET_OUTPUT_LOW(rlow), .O_FAIL_OUTPUT(fo),
      .O_THERM_HOLD(th), .O_WD_OFF_UPPER(wdu), .O_WD_OFF_LOWER(wdl), .O_WD_WINDOW(win),
      .O_WD_CHECKSUM(cks), .O_WD_PERIOD(per), .O_WD_PERIOD_MS(pms),
      .O_WD_LONG_OPEN_START(lo));

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic chk_bit(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask : chk_bit

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      u_host.xfer(1'b1, a, d);
   endtask : wr

   // Expected read data is queued; the watcher below pops it when data lands
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      u_host.xfer(1'b0, a, 16'h0000);
   endtask : rd

   task automatic pulse(input int k);
      @(negedge clk);
      ev[k] = 1'b1;
      @(negedge clk);
      ev[k] = 1'b0;
   endtask : pulse

   // Bounded so a stuck level cannot hang the run
   task automatic hold_len(input int k, output int len);
      len = 0;
      while (((k == 0) ? rlow : th) === 1'b1 && len < 5000)
      begin
         len++;
         @(negedge clk);
      end
      if (len == 5000)
      begin
         n_mismatch++;
         results();
      end
   endtask : hold_len

   always @(posedge clk) rd_q <= rd_en;

   always @(negedge clk)
   begin
      if (rd_q === 1'b1 && exp_q.size() > 0)
         chk(rdat, exp_q.pop_front());
   end

   initial
   begin
      repeat (100000) @(negedge clk);
      n_mismatch++;
      results();
   end

   initial
   begin
      seed = 32'hb477;
      ev = 6'h00;
      pin_fo = 1'b0;
      fail_st = 1'b0;
      rst = 1'b1;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      rd(7'h02, 16'h0000);
      rd(7'h03, 16'h0014);
      wr(7'h02, 16'hFFFF);
      rd(7'h02, 16'h1E64);
      chk({12'h000, ov, sh, rdly, wdu}, 16'h000F);
      repeat (4)
      begin
         v = 16'($random(seed));
         wr(7'h03, v);
         rd(7'h03, v & 16'h8077);
         chk({13'h0000, win, wdl, cks}, {13'h0000, v[5], v[6], v[15]});
      end
      wr(7'h05, 16'hFFFF);
      rd(7'h05, 16'h0000);
      $display("test registers done");
      for (int c = 0; c < 8; c++)
      begin
         wr(7'h03, 16'(c));
         @(negedge clk);
         chk({13'h0000, per}, 16'(c));
         chk({2'b00, pms}, 16'(ms_tab[c]));
      end
      $display("test periods done");
      wr(7'h02, 16'h0004);
      chk_bit(wdu, 1'b1);
      pulse(2);
      rd(7'h02, 16'h0000);
      chk_bit(wdu, 1'b0);
      wr(7'h02, 16'h0020);
      @(negedge clk);
      chk_bit(fo, 1'b0);
      pin_fo = 1'b1;
      @(negedge clk);
      chk_bit(fo, 1'b1);
      fail_st = 1'b1;
      wr(7'h02, 16'h0000);
      @(negedge clk);
      chk_bit(fo, 1'b1);
      fail_st = 1'b0;
      @(negedge clk);
      chk_bit(fo, 1'b0);
      wr(7'h02, 16'h1E64);
      wr(7'h03, 16'h8077);
      @(negedge clk);
      chk_bit(fo, 1'b1);
      pulse(1);
      rd(7'h02, 16'h1240);
      rd(7'h03, 16'h0014);
      chk_bit(fo, 1'b0);
      $display("test fail output done");
      pulse(0);
      chk_bit(rlow, 1'b0);
      rd(7'h02, 16'h0200);
      rd(7'h03, 16'h0014);
      wr(7'h02, 16'h0200);
      pulse(0);
      hold_len(0, n);
      chk(16'(n), 16'(RS));
      wr(7'h02, 16'h0000);
      pulse(0);
      hold_len(0, n);
      chk(16'(n), 16'(RL));
      $display("test soft reset done");
      pulse(4);
      hold_len(1, n);
      chk(16'(n), 16'(TW));
      wr(7'h02, 16'h1000);
      pulse(5);
      repeat (17) pulse(4);
      hold_len(1, n);
      chk(16'(n), 16'(64 * TW));
      $display("test thermal done");
      pulse(3);
      chk_bit(lo, 1'b1);
      @(negedge clk);
      chk_bit(lo, 1'b0);
      wr(7'h03, 16'h0000);
      pulse(3);
      chk_bit(lo, 1'b0);
      $display("test bus wake done");
      repeat (4) @(negedge clk);
      results();
   end
endmodule : tb

/* File: verilog/hwd_pkg.sv */
// Package for the hardware-options and watchdog-setup register bank.
// Assumes a 25 MHz system clock and a 7-bit register address from the serial front end.
package hwd_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;

   localparam logic [6:0]  ADDR_HW_OPTIONS = 7'h02;
   localparam logic [6:0]  ADDR_WD_SETUP   = 7'h03;

   // hardware_options field positions
   localparam int HW_THERM_WAIT_BIT = 12;
   localparam int HW_OV_SEL_BIT     = 11;
   localparam int HW_SH_OFF_BIT     = 10;
   localparam int HW_RST_DEL_BIT    = 9;
   localparam int HW_SOFT_PIN_BIT   = 6;
   localparam int HW_FO_SW_BIT      = 5;
   localparam int HW_WD_OFF_U_BIT   = 2;

   // watchdog_setup field positions
   localparam int WD_CHECKSUM_BIT   = 15;
   localparam int WD_OFF_L_BIT      = 6;
   localparam int WD_STYLE_BIT      = 5;
   localparam int WD_BUS_START_BIT  = 4;
   localparam int WD_PERIOD_LSB     = 0;
   localparam int WD_PERIOD_W       = 3;

   localparam logic [15:0] HW_RESET_VAL    = 16'h0000;
   localparam logic [15:0] HW_WRITE_MASK   = 16'h1E64;
   localparam logic [15:0] HW_SOFT_KEEP    = 16'h0200;
   localparam logic [15:0] HW_RESTART_KEEP = 16'h1240;
   localparam logic [15:0] WD_RESET_VAL    = 16'h0014;
   localparam logic [15:0] WD_WRITE_MASK   = 16'h8077;
   localparam logic [15:0] WD_RESTART_KEEP = 16'h0010;

   // Timing, in printed units
   localparam int CLK_HZ            = 25_000_000;
   localparam int THERM_WAIT_MS     = 1000;
   localparam int THERM_LONG_MULT   = 64;
   localparam int THERM_EVENT_LIMIT = 16;
   localparam int RST_DELAY_LONG_MS = 10;
   localparam int RST_DELAY_SHORT_MS = 2;

   localparam int THERM_WAIT_CYC  = THERM_WAIT_MS * (CLK_HZ / 1000);
   localparam int RST_LONG_CYC    = RST_DELAY_LONG_MS * (CLK_HZ / 1000);
   localparam int RST_SHORT_CYC   = RST_DELAY_SHORT_MS * (CLK_HZ / 1000);

   function automatic logic [13:0] wd_period_ms(input logic [2:0] code);
      logic [13:0] ms;
      ms = 14'h0000;
      unique case (code)
         3'h0: ms = 14'd10;
         3'h1: ms = 14'd20;
         3'h2: ms = 14'd50;
         3'h3: ms = 14'd100;
         3'h4: ms = 14'd200;
         3'h5: ms = 14'd500;
         3'h6: ms = 14'd1000;
         3'h7: ms = 14'd10000;
      endcase
      return ms;
   endfunction : wd_period_ms
endpackage : hwd_pkg

/* File: verilog/hwd_regs.sv */
// Hardware-options and watchdog-setup register bank with its side effects.
// Assumes the serial front end delivers decoded register accesses on this clock,
// and that mode and thermal events arrive as same-clock single-cycle pulses, and the failure status as a level.
`timescale 1ns/1ps

module hwd_regs #(
   parameter int THERM_WAIT_CYC = hwd_pkg::THERM_WAIT_CYC,
   parameter int RST_LONG_CYC   = hwd_pkg::RST_LONG_CYC,
   parameter int RST_SHORT_CYC  = hwd_pkg::RST_SHORT_CYC
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_WR_EN,
   input  wire logic        I_RD_EN,
   input  wire logic [6:0]  I_ADDR,
   input  wire logic [15:0] I_WR_DATA,
   input  wire logic        I_SOFT_RESET_REQ,
   input  wire logic        I_RESTART_ENTRY,
   input  wire logic        I_STOP_TO_NORMAL,
   input  wire logic        I_BUS_WAKE_IN_STOP,
   input  wire logic        I_PIN_IS_FAIL_OUT,
   input  wire logic        I_FAILURE_STATUS,
   input  wire logic        I_THERM_EVENT,
   input  wire logic        I_THERM_CALM,
   output logic [15:0]      O_RD_DATA,
   output logic             O_OV_THRESH_HIGH,
   output logic             O_SAMPLE_HOLD_OFF,
   output logic             O_RESET_DELAY_SHORT,
   output logic             O_RESET_OUTPUT_LOW,
   output logic             O_FAIL_OUTPUT,
   output logic             O_THERM_HOLD,
   output logic             O_WD_OFF_UPPER,
   output logic             O_WD_OFF_LOWER,
   output logic             O_WD_WINDOW,
   output logic             O_WD_CHECKSUM,
   output logic [2:0]       O_WD_PERIOD,
   output logic [13:0]      O_WD_PERIOD_MS,
   output logic             O_WD_LONG_OPEN_START
);

   localparam int THERM_LONG_CYC = THERM_WAIT_CYC * hwd_pkg::THERM_LONG_MULT;

   // Upper bound keeps the sixty-four-fold wait inside a 32-bit counter
   if (THERM_WAIT_CYC < 1 || RST_SHORT_CYC < 1 || RST_LONG_CYC < 1 ||
       THERM_WAIT_CYC > 32'h01FF_FFFF)
   begin : g_bad_timing
      $error("hwd_regs: timing parameter out of range");
   end

   logic [15:0] hw_r;
   logic [15:0] wd_r;
   logic [15:0] rd_data_r;
   logic        fail_r;
   logic        rst_low_r;
   logic [31:0] rst_cnt_r;
   logic        hold_r;
   logic [31:0] therm_cnt_r;
   logic [4:0]  evt_cnt_r;
   logic [4:0]  evt_cnt_nxt;
   logic        wake_start_r;
   logic [13:0] period_ms_r;
   logic        wr_hw;
   logic        wr_wd;

   assign wr_hw = I_WR_EN && (I_ADDR == hwd_pkg::ADDR_HW_OPTIONS);
   assign wr_wd = I_WR_EN && (I_ADDR == hwd_pkg::ADDR_WD_SETUP);

   // Restart outranks soft reset; a write in the same cycle is dropped then
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         hw_r <= hwd_pkg::HW_RESET_VAL;
      else if (I_RESTART_ENTRY)
         hw_r <= hw_r & hwd_pkg::HW_RESTART_KEEP;
      else if (I_SOFT_RESET_REQ)
         hw_r <= hw_r & hwd_pkg::HW_SOFT_KEEP;
      else
      begin
         if (I_STOP_TO_NORMAL)
            hw_r[hwd_pkg::HW_WD_OFF_U_BIT] <= 1'b0;
         // A host write in the same cycle wins over the automatic clear
         if (wr_hw)
            hw_r <= I_WR_DATA & hwd_pkg::HW_WRITE_MASK;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         wd_r <= hwd_pkg::WD_RESET_VAL;
      else if (I_RESTART_ENTRY)
         wd_r <= (wd_r & hwd_pkg::WD_RESTART_KEEP) |
                 (hwd_pkg::WD_RESET_VAL & ~hwd_pkg::WD_RESTART_KEEP);
      else if (I_SOFT_RESET_REQ)
         wd_r <= hwd_pkg::WD_RESET_VAL;
      else if (wr_wd)
         wd_r <= I_WR_DATA & hwd_pkg::WD_WRITE_MASK;
   end

   // Read data is captured before any same-cycle write lands
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         rd_data_r <= 16'h0000;
      else if (I_RD_EN)
      begin
         if (I_ADDR == hwd_pkg::ADDR_HW_OPTIONS)
            rd_data_r <= hw_r;
         else if (I_ADDR == hwd_pkg::ADDR_WD_SETUP)
            rd_data_r <= wd_r;
         else
            rd_data_r <= 16'h0000;
      end
   end

   // Failure-driven activation is independent of the software bit
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         fail_r <= 1'b0;
      else
         fail_r <= (hw_r[hwd_pkg::HW_FO_SW_BIT] && I_PIN_IS_FAIL_OUT) ||
                   I_FAILURE_STATUS;
   end

   // Reset output pulse length follows the delay select, which survives soft reset
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         rst_low_r <= 1'b0;
         rst_cnt_r <= 32'h0000_0000;
      end
      else if (I_SOFT_RESET_REQ && !I_RESTART_ENTRY && !hw_r[hwd_pkg::HW_SOFT_PIN_BIT])
      begin
         rst_low_r <= 1'b1;
         rst_cnt_r <= hw_r[hwd_pkg::HW_RST_DEL_BIT] ? 32'(RST_SHORT_CYC - 1)
                                                    : 32'(RST_LONG_CYC - 1);
      end
      else if (rst_low_r)
      begin
         if (rst_cnt_r == 32'h0000_0000)
            rst_low_r <= 1'b0;
         else
            rst_cnt_r <= rst_cnt_r - 32'h0000_0001;
      end
   end

   // Consecutive thermal event count saturates just past the limit
   always_comb
   begin
      evt_cnt_nxt = evt_cnt_r;
      if (evt_cnt_r <= 5'(hwd_pkg::THERM_EVENT_LIMIT))
         evt_cnt_nxt = evt_cnt_r + 5'h01;
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
         evt_cnt_r <= 5'h00;
      else if (I_THERM_EVENT)
         evt_cnt_r <= evt_cnt_nxt;
      else if (I_THERM_CALM)
         evt_cnt_r <= 5'h00;
   end

   // A new event while waiting restarts the full wait
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         hold_r      <= 1'b0;
         therm_cnt_r <= 32'h0000_0000;
      end
      else if (I_THERM_EVENT)
      begin
         hold_r <= 1'b1;
         if (hw_r[hwd_pkg::HW_THERM_WAIT_BIT] &&
             evt_cnt_nxt > 5'(hwd_pkg::THERM_EVENT_LIMIT))
            therm_cnt_r <= 32'(THERM_LONG_CYC - 1);
         else
            therm_cnt_r <= 32'(THERM_WAIT_CYC - 1);
      end
      else if (hold_r)
      begin
         if (therm_cnt_r == 32'h0000_0000)
            hold_r <= 1'b0;
         else
            therm_cnt_r <= therm_cnt_r - 32'h0000_0001;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         wake_start_r <= 1'b0;
         period_ms_r  <= 14'h0000;
      end
      else
      begin
         wake_start_r <= I_BUS_WAKE_IN_STOP && wd_r[hwd_pkg::WD_BUS_START_BIT];
         period_ms_r  <= hwd_pkg::wd_period_ms(wd_r[2:0]);
      end
   end

   assign O_RD_DATA            = rd_data_r;
   assign O_OV_THRESH_HIGH     = hw_r[hwd_pkg::HW_OV_SEL_BIT];
   assign O_SAMPLE_HOLD_OFF    = hw_r[hwd_pkg::HW_SH_OFF_BIT];
   assign O_RESET_DELAY_SHORT  = hw_r[hwd_pkg::HW_RST_DEL_BIT];
   assign O_RESET_OUTPUT_LOW   = rst_low_r;
   assign O_FAIL_OUTPUT        = fail_r;
   assign O_THERM_HOLD         = hold_r;
   assign O_WD_OFF_UPPER       = hw_r[hwd_pkg::HW_WD_OFF_U_BIT];
   assign O_WD_OFF_LOWER       = wd_r[hwd_pkg::WD_OFF_L_BIT];
   assign O_WD_WINDOW          = wd_r[hwd_pkg::WD_STYLE_BIT];
   assign O_WD_CHECKSUM        = wd_r[hwd_pkg::WD_CHECKSUM_BIT];
   assign O_WD_PERIOD          = wd_r[2:0];
   assign O_WD_PERIOD_MS       = period_ms_r;
   assign O_WD_LONG_OPEN_START = wake_start_r;

   property p_hw_reserved;
      @(posedge I_CLK) disable iff (I_RST)
      (hw_r & ~hwd_pkg::HW_WRITE_MASK) == 16'h0000;
   endproperty
   a_hw_reserved: assert property (p_hw_reserved) else $error("reserved hw bit set");

   property p_wd_reserved;
      @(posedge I_CLK) disable iff (I_RST)
      I_RD_EN && I_ADDR == hwd_pkg::ADDR_WD_SETUP
         |=> (O_RD_DATA & ~hwd_pkg::WD_WRITE_MASK) == 16'h0000;
   endproperty
   a_wd_reserved: assert property (p_wd_reserved) else $error("reserved wd bit read");

   property p_hw_write;
      @(posedge I_CLK) disable iff (I_RST)
      wr_hw && !I_RESTART_ENTRY && !I_SOFT_RESET_REQ
         |=> hw_r == ($past(I_WR_DATA) & hwd_pkg::HW_WRITE_MASK);
   endproperty
   a_hw_write: assert property (p_hw_write) else $error("hw write not stored");

   property p_failure_holds;
      @(posedge I_CLK) disable iff (I_RST)
      I_FAILURE_STATUS |=> O_FAIL_OUTPUT;
   endproperty
   a_failure_holds: assert property (p_failure_holds) else $error("fail output dropped");

   property p_restart_fo;
      @(posedge I_CLK) disable iff (I_RST)
      I_RESTART_ENTRY ##1 !I_FAILURE_STATUS |=> !O_FAIL_OUTPUT;
   endproperty
   a_restart_fo: assert property (p_restart_fo) else $error("fail output after restart");

   property p_stop_clear;
      @(posedge I_CLK) disable iff (I_RST)
      I_STOP_TO_NORMAL && !wr_hw |=> !O_WD_OFF_UPPER;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("upper disable not cleared");

   property p_soft_pulse;
      @(posedge I_CLK) disable iff (I_RST)
      I_SOFT_RESET_REQ && !I_RESTART_ENTRY && !rst_low_r
         |=> O_RESET_OUTPUT_LOW == !$past(hw_r[hwd_pkg::HW_SOFT_PIN_BIT]);
   endproperty
   a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse wrong");

   property p_therm_long;
      @(posedge I_CLK) disable iff (I_RST)
      I_THERM_EVENT && hw_r[hwd_pkg::HW_THERM_WAIT_BIT] &&
         evt_cnt_r >= 5'(hwd_pkg::THERM_EVENT_LIMIT)
         |=> O_THERM_HOLD && therm_cnt_r == 32'(THERM_LONG_CYC - 1);
   endproperty
   a_therm_long: assert property (p_therm_long) else $error("long thermal wait missing");

   property p_bus_wake;
      @(posedge I_CLK) disable iff (I_RST)
      I_BUS_WAKE_IN_STOP |=> O_WD_LONG_OPEN_START == $past(wd_r[hwd_pkg::WD_BUS_START_BIT]);
   endproperty
   a_bus_wake: assert property (p_bus_wake) else $error("bus wake start wrong");

   property p_rst_short;
      @(posedge I_CLK) disable iff (I_RST)
      I_SOFT_RESET_REQ && !I_RESTART_ENTRY && !hw_r[hwd_pkg::HW_SOFT_PIN_BIT] &&
         hw_r[hwd_pkg::HW_RST_DEL_BIT] |=> rst_cnt_r == 32'(RST_SHORT_CYC - 1);
   endproperty
   a_rst_short: assert property (p_rst_short) else $error("short reset delay missing");

   property p_therm_short;
      @(posedge I_CLK) disable iff (I_RST)
      I_THERM_EVENT && !hw_r[hwd_pkg::HW_THERM_WAIT_BIT]
         |=> O_THERM_HOLD && therm_cnt_r == 32'(THERM_WAIT_CYC - 1);
   endproperty
   a_therm_short: assert property (p_therm_short) else $error("one second wait missing");

endmodule : hwd_regs
